// *** logic/sipo_latch.sv ***
// Serial-in, parallel-out latch with open-drain sinks
//
// Summary of operation
// - Eight-stage shift register feeds eight-bit storage
// - Shift on shift edge; load edge queues the word, storage takes it when storage_ready is high
// - Storage reaches outputs only while clear high
// - Clear low zeroes shift stages, buffer, storage and cascade
// - Enable high forces all sinks off
// - Enable low: sinks follow storage combinationally
// - Sink pulls low when its bit is one
// - Cascade output carries shift data onward
`timescale 1ns/1ps
`default_nettype none
`include "sipo_latch_cfg.svh"
module sipo_latch
	import sipo_latch_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      srst,
	input  wire pins_type  pins,
	input  wire logic      storage_ready,
	output logic           load_ready,
	output drive_type      drive
);

	////////////////////////////////////////////////////////////////////////////
	// State

	state_type st_q;
	state_type st_d;
	logic      shift_edge;
	logic      load_edge;
	logic      push;
	logic      pop;
	logic      passing;

	// Rising edge of a synchronised pin against the level seen one clock earlier
	function automatic logic rising(input logic now_level, input logic last_level);
		return now_level & ~last_level;
	endfunction

	// Pins come from another domain, so only the second stage is ever decoded
	assign shift_edge = rising(st_q.sync2.shift_clock, st_q.shift_clock_prev);
	assign load_edge  = rising(st_q.sync2.storage_load_clock, st_q.load_clock_prev);
	assign load_ready = (st_q.fill != `BUF_DEPTH);
	// A load edge while both entries wait is dropped; load_ready warns of that
	assign push       = load_edge & load_ready;
	assign pop        = (st_q.fill != `BUF_EMPTY) & storage_ready;
	assign passing    = st_q.sync2.register_clear_n & ~st_q.sync2.output_enable_n;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d                  = st_q;
		st_d.sync1            = pins;
		st_d.sync2            = st_q.sync1;
		st_d.shift_clock_prev = st_q.sync2.shift_clock;
		st_d.load_clock_prev  = st_q.sync2.storage_load_clock;
		if (shift_edge) begin
			st_d.shift_stages = {st_q.shift_stages[`STAGE_COUNT-2:0], st_q.sync2.serial_input};
		end
		if (push) begin
			if (st_q.wr_ptr) begin
				st_d.entry1 = st_q.shift_stages;
			end else begin
				st_d.entry0 = st_q.shift_stages;
			end
			st_d.wr_ptr = ~st_q.wr_ptr;
		end
		if (pop) begin
			st_d.storage = st_q.rd_ptr ? st_q.entry1 : st_q.entry0;
			st_d.rd_ptr  = ~st_q.rd_ptr;
		end
		st_d.fill    = st_q.fill + {1'b0, push} - {1'b0, pop};
		st_d.cascade = st_d.shift_stages[`CASCADE_STAGE];
		if (!st_q.sync2.register_clear_n) begin
			st_d.shift_stages = `STAGE_ZERO;
			st_d.entry0       = `STAGE_ZERO;
			st_d.entry1       = `STAGE_ZERO;
			st_d.storage      = `STAGE_ZERO;
			st_d.wr_ptr       = 1'b0;
			st_d.rd_ptr       = 1'b0;
			st_d.fill         = `BUF_EMPTY;
			st_d.cascade      = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sink drive: open drain, so the output value is always low

	always_comb begin
		drive.sink_out       = `STAGE_ZERO;
		drive.sink_oe        = passing ? st_q.storage : `STAGE_ZERO;
		drive.cascade_output = st_q.cascade;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	// Checks read the synchronised pins, as the logic does, so pin skew never trips them
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_shift_in;
		shift_edge && st_q.sync2.register_clear_n |=>
			st_q.shift_stages == {$past(st_q.shift_stages[`STAGE_COUNT-2:0]), $past(st_q.sync2.serial_input)};
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("shift stage did not advance");

	property p_load_path;
		push && !pop && st_q.fill == `BUF_EMPTY && st_q.sync2.register_clear_n
			##1 storage_ready && st_q.sync2.register_clear_n |=> st_q.storage == $past(st_q.shift_stages, 2);
	endproperty
	a_load_path: assert property (p_load_path) else $error("storage missed loaded word");

	property p_clear_zero;
		!st_q.sync2.register_clear_n |=> st_q.shift_stages == 8'h00 && st_q.storage == 8'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear left data behind");

	property p_clear_blocks;
		!st_q.sync2.register_clear_n |-> drive.sink_oe == 8'h00;
	endproperty
	a_clear_blocks: assert property (p_clear_blocks) else $error("sinks on during clear");

	property p_enable_off;
		st_q.sync2.output_enable_n |-> drive.sink_oe == 8'h00;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("sinks on with enable high");

	property p_enable_follow;
		passing |-> drive.sink_oe == st_q.storage;
	endproperty
	a_enable_follow: assert property (p_enable_follow) else $error("sinks do not follow storage");

	property p_sink_low;
		drive.sink_out == 8'h00;
	endproperty
	a_sink_low: assert property (p_sink_low) else $error("sink drives high");

	property p_cascade_eight;
		shift_edge && st_q.sync2.register_clear_n && st_q.shift_stages[6] |=>
			drive.cascade_output || !$past(st_q.sync2.register_clear_n);
	endproperty
	a_cascade_eight: assert property (p_cascade_eight) else $error("stage six missed cascade");

	property p_cascade_tap;
		##1 drive.cascade_output == st_q.shift_stages[7];
	endproperty
	a_cascade_tap: assert property (p_cascade_tap) else $error("cascade not last stage");

	property p_load_refused;
		load_edge && !load_ready && st_q.sync2.register_clear_n |=>
			$stable(st_q.entry0) && $stable(st_q.entry1);
	endproperty
	a_load_refused: assert property (p_load_refused) else $error("full buffer took a word");

	property p_fill_bound;
		st_q.fill <= `BUF_DEPTH;
	endproperty
	a_fill_bound: assert property (p_fill_bound) else $error("buffer fill beyond two");

	property p_full_blocks;
		st_q.fill == `BUF_DEPTH |-> !load_ready;
	endproperty
	a_full_blocks: assert property (p_full_blocks) else $error("load ready while full");

	property p_stages_hold;
		!shift_edge && st_q.sync2.register_clear_n |=>
			$stable(st_q.shift_stages);
	endproperty
	a_stages_hold: assert property (p_stages_hold) else $error("shift stages moved without edge");

	property p_storage_hold;
		!pop && st_q.sync2.register_clear_n |=>
			$stable(st_q.storage);
	endproperty
	a_storage_hold: assert property (p_storage_hold) else $error("storage moved without load");

	property p_cascade_clear;
		!st_q.sync2.register_clear_n |=> !drive.cascade_output;
	endproperty
	a_cascade_clear: assert property (p_cascade_clear) else $error("cascade high after clear");

	property p_push_count;
		push && !pop && st_q.sync2.register_clear_n |=>
			st_q.fill == $past(st_q.fill) + 2'h1;
	endproperty
	a_push_count: assert property (p_push_count) else $error("fill did not rise on load");

	property p_pop_count;
		pop && !push && st_q.sync2.register_clear_n |=>
			st_q.fill == $past(st_q.fill) - 2'h1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("fill did not fall on drain");

	property p_cascade_hold;
		!shift_edge && st_q.sync2.register_clear_n |=>
			$stable(drive.cascade_output);
	endproperty
	a_cascade_hold: assert property (p_cascade_hold) else $error("cascade moved without edge");

	property p_first_stage;
		shift_edge && st_q.sync2.register_clear_n |=>
			st_q.shift_stages[0] == $past(st_q.sync2.serial_input);
	endproperty
	a_first_stage: assert property (p_first_stage) else $error("input missed stage zero");

	property p_oe_subset;
		(drive.sink_oe & ~st_q.storage) == `STAGE_ZERO;
	endproperty
	a_oe_subset: assert property (p_oe_subset) else $error("sink on for a zero bit");

endmodule // sipo_latch
`default_nettype wire

// *** logic/sipo_latch_cfg.svh ***
// Constants for the serial-in, parallel-out latch
`ifndef SIPO_LATCH_CFG_SVH
`define SIPO_LATCH_CFG_SVH
`define STAGE_COUNT     8
`define STAGE_ZERO      8'h00
`define CASCADE_STAGE   7
`define BUF_DEPTH       2'h2
`define BUF_EMPTY       2'h0
`endif

// *** logic/sipo_latch_pkg.sv ***
// Types for the serial-in, parallel-out latch
`include "sipo_latch_cfg.svh"
package sipo_latch_pkg;
	typedef logic [`STAGE_COUNT-1:0] stage_type;

	typedef struct packed {
		logic shift_clock;
		logic storage_load_clock;
		logic register_clear_n;
		logic output_enable_n;
		logic serial_input;
	} pins_type;

	typedef struct packed {
		stage_type sink_out;
		stage_type sink_oe;
		logic      cascade_output;
	} drive_type;

	typedef struct packed {
		pins_type  sync1;
		pins_type  sync2;
		logic      shift_clock_prev;
		logic      load_clock_prev;
		stage_type shift_stages;
		stage_type entry0;
		stage_type entry1;
		logic      wr_ptr;
		logic      rd_ptr;
		logic [1:0] fill;
		stage_type storage;
		logic      cascade;
	} state_type;
endpackage

// *** bench/sipo_ctrl_model.sv ***
// Controller model driving the latch pins
`timescale 1ns/1ps
`default_nettype none
module sipo_ctrl_model
	import sipo_latch_pkg::*;
(
	input  wire logic     clk,
	output var  pins_type pins
);
	initial pins = '0; // Clear held low from power-up
	////////////////////////////////////////////////////////////////
	// Each level stands at least 3 cycles so the two-flop sync never misses it
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic levels(input logic clr_n, input logic en_n); // Clear and enable set as levels, both held 4 cycles
		pins.register_clear_n = clr_n;
		pins.output_enable_n = en_n;
		hold(4);
	endtask
	task automatic shift_word(input logic [7:0] w); // First bit sent ends in the last stage
		for (int i = 7; i >= 0; i--) begin
			pins.serial_input = w[i];
			hold(3);
			pins.shift_clock = 1'b1;
			hold(3);
			pins.shift_clock = 1'b0;
		end
		hold(3);
	endtask
	task automatic load(); // Load clock low except here, once per word
		pins.storage_load_clock = 1'b1;
		hold(3);
		pins.storage_load_clock = 1'b0;
		hold(6);
	endtask
endmodule // sipo_ctrl_model
`default_nettype wire

// *** bench/test_serial_in_parallel_out_latch.sv ***
// Self-checking bench for the serial latch
`timescale 1ns/1ps
`default_nettype none
module test_serial_in_parallel_out_latch
	import sipo_latch_pkg::*;
;
	logic      clk = 1'b0;
	logic      srst = 1'b1;
	logic      storage_ready = 1'b1;
	logic      load_ready;
	pins_type  pins;
	drive_type drive;
	int        fails = 0;
	int        num_checks = 0;
	always #12.5 clk = ~clk;
	sipo_ctrl_model sipo_ctrl_model_inst (.clk(clk), .pins(pins));
	sipo_latch sipo_latch_inst (.clk(clk), .srst(srst), .pins(pins),
		.storage_ready(storage_ready), .load_ready(load_ready), .drive(drive));
	////////////////////////////////////////////////////////////////
	task automatic check8(input string what, input stage_type exp, input stage_type got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic scen_load();
		sipo_ctrl_model_inst.levels(1'b1, 1'b0);
		sipo_ctrl_model_inst.shift_word(8'hA5);
		check8("sink_oe unloaded", 8'h00, drive.sink_oe);
		sipo_ctrl_model_inst.load();
		check8("sink_oe", 8'hA5, drive.sink_oe);
		check8("sink_out", 8'h00, drive.sink_out);
		check8("cascade", 8'h01, {7'h00, drive.cascade_output});
	endtask
	task automatic scen_enable();
		sipo_ctrl_model_inst.levels(1'b1, 1'b1);
		check8("sink_oe off", 8'h00, drive.sink_oe);
		sipo_ctrl_model_inst.levels(1'b1, 1'b0);
		check8("sink_oe on", 8'hA5, drive.sink_oe);
	endtask
	task automatic scen_cascade();
		sipo_ctrl_model_inst.shift_word(8'hC3);
		check8("sink_oe held", 8'hA5, drive.sink_oe);
		check8("cascade", 8'h01, {7'h00, drive.cascade_output});
	endtask
	task automatic scen_clear();
		sipo_ctrl_model_inst.levels(1'b0, 1'b0);
		check8("sink_oe clear", 8'h00, drive.sink_oe);
		check8("cascade clear", 8'h00, {7'h00, drive.cascade_output});
		sipo_ctrl_model_inst.levels(1'b1, 1'b0);
		check8("sink_oe after clear", 8'h00, drive.sink_oe);
	endtask
	// Stalled drain: two words fill the buffer, neither of them is lost
	task automatic scen_buffer();
		storage_ready = 1'b0;
		sipo_ctrl_model_inst.shift_word(8'h0F);
		sipo_ctrl_model_inst.load();
		sipo_ctrl_model_inst.shift_word(8'hF0);
		sipo_ctrl_model_inst.load();
		check8("load_ready full", 8'h00, {7'h00, load_ready});
		check8("sink_oe stalled", 8'h00, drive.sink_oe);
		// A third word while full is dropped and must not overwrite the queue
		sipo_ctrl_model_inst.shift_word(8'h55);
		sipo_ctrl_model_inst.load();
		storage_ready = 1'b1;
		@(posedge clk);
		#2;
		check8("sink_oe first", 8'h0F, drive.sink_oe);
		repeat (8) @(posedge clk);
		#2;
		check8("sink_oe drained", 8'hF0, drive.sink_oe);
		check8("load_ready empty", 8'h01, {7'h00, load_ready});
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#2 srst = 1'b0;
		scen_load();
		scen_enable();
		scen_cascade();
		scen_clear();
		scen_buffer();
		end_of_test();
	end
endmodule // test_serial_in_parallel_out_latch
`default_nettype wire
